//--- inc/sac_pkg.sv
// constants shared by the converter sequencing block
// Notes on behaviour
// - a conversion starts on the strobe rising edge, finishes 0.5 to 1.6 us later, and starts closer than 2 us apart are not taken.
// - the serial output bit changes after each shift clock falling edge, so the host samples before the next falling edge.
// - in gated-output mode the first bit shown when the strobe or chain input goes low is the result msb.
// - in gated-output mode the output is released when strobe and chain input are both high or after the last falling edge.
// - the chain input level is sampled at the strobe rising edge and must be stable around it.
// - in chain mode the chain input is captured on every shift clock falling edge.
// - in chain mode with the busy indicator the output follows the chain input high to pass busy downstream.
// - chain input low at the strobe rising edge selects chain mode, high selects gated-output mode.
// - in chain mode each captured input level reappears on the output exactly 16 shift clocks later.
// - in gated-output mode an enable held low while converting turns on the busy indicator on the output.
package sac_pkg;

    localparam int RESULT_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAIN_DELAY = 16;

    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 1600;
    localparam int CYCLE_MIN_NS = 2000;
    localparam int SHIFT_MIN_NS = 15;

    // least times round up, longest times round down
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CYCLE_MIN_CYC = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CONV_RST = 9'h000;
    localparam logic [CNT_W-1:0] GAP_RST = 9'h0C7;
    localparam logic [RESULT_W-1:0] WORD_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_PUSH = 3'b100
    } sac_state_t;

endpackage : sac_pkg

//--- verilog/sac_sync.sv
// two-stage level synchroniser, one bit per lane
`timescale 1ns/100ps
`default_nettype none
module sac_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : sac_sync
`default_nettype wire

//--- verilog/sac_fifo.sv
// flip-flop result queue with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sac_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] wr_d;
    logic [AW:0] rd_q;
    logic [AW:0] rd_d;
    logic push;
    logic pop;

    always_comb begin
        in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid = wr_q != rd_q;
        out_data = mem_q[rd_q[AW-1:0]];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_comb begin
            mem_d[i] = mem_q[i];
            if (push && wr_q[AW-1:0] == AW'(i)) begin
                mem_d[i] = in_data;
            end
        end
        always_ff @(posedge clk) begin
            mem_q[i] <= mem_d[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
endmodule : sac_fifo
`default_nettype wire

//--- verilog/sac_top.sv
// conversion timing and serial readout of the successive-approximation core
`timescale 1ns/100ps
`default_nettype none
module sac_top #(
    parameter int W = sac_pkg::RESULT_W,
    parameter int DEPTH = sac_pkg::FIFO_DEPTH,
    parameter int CONV_CYC = sac_pkg::CONV_MAX_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic shift_clk,
    input wire logic convert_strobe,
    input wire logic serial_chain_in,
    input wire logic chain_busy_en,
    input wire logic [W-1:0] conv_code,
    output logic serial_result_out,
    output logic serial_result_oe,
    output logic sample_hold,
    output logic conv_busy,
    output logic start_ignored
);
    localparam int CW = $clog2(W) + 1;

    // ---------------- core domain ----------------
    logic [2:0] pins_s;
    logic strb_s;
    logic chin_s;
    logic busy_en_s;
    logic link_done_s;

    sac_sync #(.W(3)) u_pin_sync (
        .clk(core_clk),
        .rst(rst),
        .async_in({convert_strobe, serial_chain_in, chain_busy_en}),
        .sync_out(pins_s)
    );

    assign strb_s = pins_s[2];
    assign chin_s = pins_s[1];
    assign busy_en_s = pins_s[0];

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [W-1:0] fifo_out_data;

    sac_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(conv_code),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    sac_pkg::sac_state_t state_q;
    sac_pkg::sac_state_t state_d;
    logic [sac_pkg::CNT_W-1:0] conv_cnt_q;
    logic [sac_pkg::CNT_W-1:0] conv_cnt_d;
    logic [sac_pkg::CNT_W-1:0] gap_cnt_q;
    logic [sac_pkg::CNT_W-1:0] gap_cnt_d;
    logic strb_prev_q;
    logic strb_prev_d;
    logic chain_mode_q;
    logic chain_mode_d;
    logic sample_hold_q;
    logic sample_hold_d;
    logic busy_q;
    logic busy_d;
    logic ignored_q;
    logic ignored_d;

    logic strb_rise;
    logic strb_fall;
    logic start_ok;
    logic en_low;

    always_comb begin
        strb_rise = strb_s & ~strb_prev_q;
        strb_fall = ~strb_s & strb_prev_q;
        en_low = ~strb_s | ~chin_s;
        start_ok = (gap_cnt_q == sac_pkg::CNT_W'(sac_pkg::CYCLE_MIN_CYC - 1))
            && (state_q == sac_pkg::ST_IDLE);
        state_d = state_q;
        conv_cnt_d = conv_cnt_q;
        gap_cnt_d = gap_cnt_q;
        strb_prev_d = strb_s;
        chain_mode_d = chain_mode_q;
        sample_hold_d = 1'b0;
        ignored_d = 1'b0;
        fifo_in_valid = 1'b0;
        if (gap_cnt_q != sac_pkg::CNT_W'(sac_pkg::CYCLE_MIN_CYC - 1)) begin
            gap_cnt_d = gap_cnt_q + 1'b1;
        end
        unique case (state_q)
            sac_pkg::ST_IDLE: begin
                if (strb_rise && start_ok) begin
                    chain_mode_d = ~chin_s;
                    sample_hold_d = 1'b1;
                    conv_cnt_d = sac_pkg::CONV_RST;
                    gap_cnt_d = sac_pkg::CONV_RST;
                    state_d = sac_pkg::ST_CONV;
                end
            end
            sac_pkg::ST_CONV: begin
                if (conv_cnt_q == sac_pkg::CNT_W'(CONV_CYC - 1)) begin
                    state_d = sac_pkg::ST_PUSH;
                end else begin
                    conv_cnt_d = conv_cnt_q + 1'b1;
                end
            end
            sac_pkg::ST_PUSH: begin
                // result waits here while the queue is full
                fifo_in_valid = 1'b1;
                if (fifo_in_ready) begin
                    state_d = sac_pkg::ST_IDLE;
                end
            end
        endcase
        if (strb_rise && !start_ok) begin
            ignored_d = 1'b1;
        end
        busy_d = state_d != sac_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= sac_pkg::ST_IDLE;
            conv_cnt_q <= sac_pkg::CONV_RST;
            gap_cnt_q <= sac_pkg::GAP_RST;
            strb_prev_q <= 1'b0;
            chain_mode_q <= 1'b0;
            sample_hold_q <= 1'b0;
            busy_q <= 1'b0;
            ignored_q <= 1'b0;
        end else begin
            state_q <= state_d;
            conv_cnt_q <= conv_cnt_d;
            gap_cnt_q <= gap_cnt_d;
            strb_prev_q <= strb_prev_d;
            chain_mode_q <= chain_mode_d;
            sample_hold_q <= sample_hold_d;
            busy_q <= busy_d;
            ignored_q <= ignored_d;
        end
    end

    // ---------------- readout control ----------------
    // the word is loaded only while the link logic is held clear, so it is
    // stable for the whole frame and crosses without a synchroniser
    logic [W-1:0] tx_word_q;
    logic [W-1:0] tx_word_d;
    logic word_avail_q;
    logic word_avail_d;
    logic link_clr_q;
    logic link_clr_d;
    logic oe_q;
    logic oe_d;

    always_comb begin
        tx_word_d = tx_word_q;
        word_avail_d = word_avail_q;
        fifo_out_ready = ~word_avail_q & ~link_done_s & link_clr_q;
        if (fifo_out_valid && fifo_out_ready) begin
            tx_word_d = fifo_out_data;
            word_avail_d = 1'b1;
        end
        if (word_avail_q && link_done_s) begin
            // gated frame ends after last edge
            if (!chain_mode_q) begin
                word_avail_d = 1'b0;
            // chain frame ends when strobe drops
            end else if (strb_fall) begin
                word_avail_d = 1'b0;
            end
        end
        link_clr_d = ~word_avail_d | (~chain_mode_q & ~en_low);
        if (chain_mode_q) begin
            oe_d = 1'b1;
        end else begin
            oe_d = en_low & ((word_avail_q & ~link_done_s)
                | (state_q != sac_pkg::ST_IDLE));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_word_q <= sac_pkg::WORD_RST;
            word_avail_q <= 1'b0;
            link_clr_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            tx_word_q <= tx_word_d;
            word_avail_q <= word_avail_d;
            link_clr_q <= link_clr_d;
            oe_q <= oe_d;
        end
    end

    // ---------------- link domain (shift clock) ----------------
    // the shift clock runs only inside frames, so the link logic is held
    // clear by the core between frames instead of counting on idle edges
    logic [CW-1:0] cnt_lq;
    logic [CW-1:0] cnt_ld;
    logic [W-1:0] rx_lq;
    logic [W-1:0] rx_ld;
    logic done_lq;
    logic done_ld;

    always_comb begin
        cnt_ld = (cnt_lq == CW'(W)) ? cnt_lq : cnt_lq + 1'b1;
        rx_ld = {rx_lq[W-2:0], serial_chain_in};
        done_ld = cnt_ld == CW'(W);
    end

    always_ff @(negedge shift_clk or posedge link_clr_q) begin
        if (link_clr_q) begin
            cnt_lq <= '0;
            rx_lq <= '0;
            done_lq <= 1'b0;
        end else begin
            cnt_lq <= cnt_ld;
            rx_lq <= rx_ld;
            done_lq <= done_ld;
        end
    end

    sac_sync #(.W(1)) u_done_sync (
        .clk(core_clk),
        .rst(rst),
        .async_in(done_lq),
        .sync_out(link_done_s)
    );

    // ---------------- serial output select ----------------
    // the bit select mixes a link counter with stable core words; it must
    // follow the falling edge within one shift period, so it is not retimed
    logic out_bit;

    always_comb begin
        if (!word_avail_q) begin
            if (chain_mode_q) begin
                out_bit = busy_en_s & chin_s;
            end else begin
                out_bit = 1'b1;
            end
        end else if (cnt_lq < CW'(W)) begin
            out_bit = tx_word_q[(W - 1) - int'(cnt_lq)];
        end else begin
            out_bit = rx_lq[W-1];
        end
    end

    assign serial_result_out = out_bit;
    assign serial_result_oe = oe_q;
    assign sample_hold = sample_hold_q;
    assign conv_busy = busy_q;
    assign start_ignored = ignored_q;
endmodule : sac_top
`default_nettype wire

//--- tb/sac_top_props.sv
// port checks for the conversion and readout block
`timescale 1ns/100ps
`default_nettype none
module sac_top_props #(
    parameter int CONV_CYC = 160
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic convert_strobe,
    input wire logic serial_chain_in,
    input wire logic chain_busy_en,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic sample_hold,
    input wire logic conv_busy,
    input wire logic start_ignored
);
    logic rise, strb_q, strb_d, gated_q, gated_d, seen_q, seen_d;
    logic [15:0] bcnt_q, bcnt_d;
    // mode is taken from the raw pins, so the host must hold them still
    always_comb begin
        rise = convert_strobe && !strb_q;
        strb_d = convert_strobe;
        gated_d = rise ? serial_chain_in : gated_q;
        seen_d = seen_q || rise;
        bcnt_d = conv_busy ? bcnt_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strb_q <= 1'b0;
            gated_q <= 1'b0;
            seen_q <= 1'b0;
            bcnt_q <= 16'h0000;
        end else begin
            strb_q <= strb_d;
            gated_q <= gated_d;
            seen_q <= seen_d;
            bcnt_q <= bcnt_d;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_hold_pulse: assert property (sample_hold |=> !sample_hold)
        else $error("sample pulse longer than one cycle");
    chk_hold_busy: assert property (sample_hold |-> conv_busy &&
        !$past(conv_busy)) else $error("start taken while busy");
    chk_ignore_only: assert property (start_ignored |->
        !sample_hold ##1 !start_ignored) else $error("refusal misbehaves");
    chk_conv_time: assert property ($fell(conv_busy) |->
        bcnt_q >= 16'(CONV_CYC)) else $error("conversion ended early");
    chk_gated_quiet: assert property (gated_q &&
        (convert_strobe && serial_chain_in)[*8] |-> !serial_result_oe)
        else $error("output driven while disabled");
    chk_gated_busy: assert property ((gated_q && conv_busy &&
        bcnt_q < 16'h0028 && !(convert_strobe && serial_chain_in))[*6]
        |-> serial_result_oe)
        else $error("busy indicator missing");
    chk_chain_drive: assert property ((seen_q && !gated_q &&
        convert_strobe)[*8] |-> serial_result_oe)
        else $error("chain output not driven");
    chk_chain_busy: assert property ((seen_q && !gated_q &&
        chain_busy_en && convert_strobe && conv_busy && serial_chain_in)[*5]
        |-> serial_result_out) else $error("busy not passed down chain");
endmodule : sac_top_props
`default_nettype wire

//--- tb/sac_host.sv
// host model: convert strobe, chain input and a gated shift clock
`timescale 1ns/100ps
`default_nettype none
module sac_host (
    input wire logic core_clk,
    input wire logic serial_result_out,
    output logic shift_clk,
    output logic convert_strobe,
    output logic serial_chain_in
);
    initial begin
        shift_clk = 1'b0;
        convert_strobe = 1'b0;
        serial_chain_in = 1'b1;
    end
    // mode level held around the rise
    task automatic start(input logic gated);
        @(negedge core_clk);
        serial_chain_in = gated;
        convert_strobe = 1'b0;
        repeat (4) @(negedge core_clk);
        convert_strobe = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : start
    task automatic set(input logic s, input logic c);
        @(negedge core_clk);
        convert_strobe = s;
        serial_chain_in = c;
    endtask : set
    // 48 ns period, bit taken just before each fall
    task automatic shift(input int n, input logic [31:0] feed,
                         output logic [31:0] got);
        got = 32'h00000000;
        @(negedge core_clk);
        #3;
        for (int i = 0; i < n; i++) begin
            serial_chain_in = feed[n-1-i];
            shift_clk = 1'b1;
            #24;
            got = {got[30:0], serial_result_out};
            shift_clk = 1'b0;
            #24;
        end
    endtask : shift
endmodule : sac_host
`default_nettype wire

//--- tb/test_sar_adc_convert_readout_timing.sv
// bench for the conversion timing and serial readout block
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_convert_readout_timing;
    localparam int CONV = 50;
    logic core_clk, rst, chain_busy_en, shift_clk, convert_strobe;
    logic serial_chain_in, serial_result_out, serial_result_oe;
    logic sample_hold, conv_busy, start_ignored;
    logic [sac_pkg::RESULT_W-1:0] conv_code;
    logic [31:0] got;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_hold = 0;
    int n_ign = 0;
    sac_top #(.CONV_CYC(CONV)) sac_top_inst (.core_clk(core_clk), .rst(rst),
        .shift_clk(shift_clk), .convert_strobe(convert_strobe),
        .serial_chain_in(serial_chain_in), .chain_busy_en(chain_busy_en),
        .conv_code(conv_code), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .sample_hold(sample_hold),
        .conv_busy(conv_busy), .start_ignored(start_ignored));
    sac_host sac_host_inst (.core_clk(core_clk),
        .serial_result_out(serial_result_out), .shift_clk(shift_clk),
        .convert_strobe(convert_strobe), .serial_chain_in(serial_chain_in));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge core_clk) begin
        cyc++;
        if (sample_hold === 1'b1) n_hold++;
        if (start_ignored === 1'b1) n_ign++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic wait_idle();
        for (int i = 0; i < 400 && conv_busy !== 1'b0; i++)
            @(negedge core_clk);
        cmp("idle", 32'h0, {31'h0, conv_busy});
    endtask : wait_idle
    task automatic wait_oe();
        for (int i = 0; i < 40 && serial_result_oe !== 1'b1; i++)
            @(negedge core_clk);
        cmp("oe_on", 32'h1, {31'h0, serial_result_oe});
    endtask : wait_oe
    // chain input is the enable here: a strobe rise would start a conversion
    task automatic rd(input logic [15:0] exp, input logic last);
        sac_host_inst.set(1'b1, 1'b0);
        wait_oe();
        sac_host_inst.shift(16, 32'h00000000, got);
        cmp("word", {16'h0000, exp}, got);
        repeat (8) @(negedge core_clk);
        if (last) cmp("oe_end", 32'h0, {31'h0, serial_result_oe});
        sac_host_inst.set(1'b1, 1'b1);
        repeat (8) @(negedge core_clk);
    endtask : rd
    task automatic t_refuse();
        int h0;
        int i0;
        h0 = n_hold;
        i0 = n_ign;
        conv_code = 16'hA5C3;
        sac_host_inst.start(1'b1);
        sac_host_inst.start(1'b1);
        wait_idle();
        sac_host_inst.start(1'b1);
        repeat (200) @(negedge core_clk);
        conv_code = 16'h3C5A;
        sac_host_inst.start(1'b1);
        wait_idle();
        cmp("taken", 32'h00000002, n_hold - h0);
        cmp("refused", 32'h00000002, n_ign - i0);
        rd(16'hA5C3, 1'b0);
        rd(16'h3C5A, 1'b1);
    endtask : t_refuse
    task automatic t_abort();
        conv_code = 16'hB00D;
        sac_host_inst.start(1'b1);
        wait_idle();
        sac_host_inst.set(1'b0, 1'b1);
        wait_oe();
        sac_host_inst.shift(5, 32'hFFFFFFFF, got);
        cmp("part_word", 32'h00000016, got);
        // this rise lands inside the 2 us gap, so no conversion starts
        sac_host_inst.set(1'b1, 1'b1);
        repeat (8) @(negedge core_clk);
        cmp("oe_off", 32'h0, {31'h0, serial_result_oe});
        rd(16'hB00D, 1'b1);
    endtask : t_abort
    task automatic t_busy();
        conv_code = 16'h7E81;
        sac_host_inst.start(1'b1);
        sac_host_inst.set(1'b1, 1'b0);
        repeat (8) @(negedge core_clk);
        cmp("busy", 32'h3, {30'h0, serial_result_oe, serial_result_out});
        wait_idle();
        repeat (4) @(negedge core_clk);
        rd(16'h7E81, 1'b1);
    endtask : t_busy
    task automatic t_chain();
        chain_busy_en = 1'b1;
        conv_code = 16'hC3A5;
        sac_host_inst.start(1'b0);
        sac_host_inst.set(1'b1, 1'b1);
        repeat (6) @(negedge core_clk);
        cmp("busy_pass", 32'h1, {31'h0, serial_result_out});
        sac_host_inst.set(1'b1, 1'b0);
        repeat (6) @(negedge core_clk);
        cmp("busy_clear", 32'h0, {31'h0, serial_result_out});
        wait_idle();
        repeat (4) @(negedge core_clk);
        sac_host_inst.shift(32, 32'h96E10000, got);
        cmp("chain", 32'hC3A596E1, got);
        sac_host_inst.set(1'b0, 1'b0);
        chain_busy_en = 1'b0;
    endtask : t_chain
    task automatic t_fifo();
        for (int i = 0; i < 10; i++) begin
            conv_code = 16'h0F00 + 16'(i);
            sac_host_inst.start(1'b1);
            repeat (210) @(negedge core_clk);
        end
        // tenth result must wait for room while the reader stalls
        cmp("queue_stall", 32'h1, {31'h0, conv_busy});
        for (int i = 0; i < 10; i++) rd(16'h0F00 + 16'(i), i == 9);
    endtask : t_fifo
    initial begin
        rst = 1'b1;
        chain_busy_en = 1'b0;
        conv_code = 16'h0000;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        t_refuse();
        repeat (200) @(negedge core_clk);
        t_abort();
        repeat (200) @(negedge core_clk);
        t_busy();
        repeat (200) @(negedge core_clk);
        t_chain();
        repeat (200) @(negedge core_clk);
        t_fifo();
        tally_and_finish();
    end
endmodule : test_sar_adc_convert_readout_timing
bind sac_top sac_top_props #(.CONV_CYC(CONV_CYC)) sac_top_props_inst (
    .core_clk(core_clk), .rst(rst), .convert_strobe(convert_strobe),
    .serial_chain_in(serial_chain_in), .chain_busy_en(chain_busy_en),
    .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .sample_hold(sample_hold),
    .conv_busy(conv_busy), .start_ignored(start_ignored));
`default_nettype wire
